/* File: rtl/alu_slice.sv */
// four-bit cascadable datapath slice with register file, ALU, Q register and AXI4-Lite status
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module alu_slice import alu_slice_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// microinstruction and data from the controller
	input wire logic [2:0] operandSourceSelect,
	input wire logic [2:0] aluFunctionSelect,
	input wire logic [2:0] destinationSelect,
	input wire logic [3:0] readPortASelect,
	input wire logic [3:0] readWritePortBSelect,
	input wire logic [3:0] dataIn,
	input wire logic carryInput,
	input wire logic regfileWriteEnable,
	// result outputs
	output logic [3:0] yOut,
	output logic yOe_b,
	output logic signBitOut,
	output logic carryOutput,
	output logic overflowFlag,
	output logic generate_b,
	output logic propagate_b,
	output logic zeroOut,
	output logic zeroOe_b,
	// shift pins shared with neighbouring slices
	input wire logic regfileLsbShiftIn,
	output logic regfileLsbShiftOut,
	output logic regfileLsbShiftOe_b,
	input wire logic regfileMsbShiftIn,
	output logic regfileMsbShiftOut,
	output logic regfileMsbShiftOe_b,
	input wire logic accumLsbShiftIn,
	output logic accumLsbShiftOut,
	output logic accumLsbShiftOe_b,
	input wire logic accumMsbShiftIn,
	output logic accumMsbShiftOut,
	output logic accumMsbShiftOe_b,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// =====================================================================
	// state
	typedef struct packed {
		pins_t pinSync1;
		pins_t pinSync2;
		logic [15:0][3:0] regFile;
		logic [3:0] q;
		logic [3:0] y;
		logic yOe_b;
		logic sign;
		logic carryOut;
		logic overflow;
		logic gen_b;
		logic prop_b;
		logic zeroOut;
		logic zeroOe_b;
		logic [3:0] shiftOut;
		logic [3:0] shiftOe_b;
		logic yEnable;
		logic awGot;
		logic wGot;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} state_t;

	state_t cur;
	state_t next_cur;
	logic rstSync1;
	logic rstSync2;
	pins_t pinsNow;
	pins_t p;
	logic [3:0] aLatch;
	logic [3:0] bLatch;
	logic [3:0] rOp;
	logic [3:0] sOp;
	logic [3:0] addA;
	logic [3:0] addB;
	logic [4:0] sum;
	logic [3:0] lowSum;
	logic [3:0] f;
	logic [3:0] g;
	logic [3:0] pr;
	logic arith;
	logic rfWrite;
	logic [3:0] rfData;
	logic [31:0] statusWord;

	// =====================================================================
	// reset release and pin sampling
	// release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// every microinstruction, data and shift-in pin passes two flops; results trail the pins by three edges
	assign pinsNow = {operandSourceSelect, aluFunctionSelect, destinationSelect, readPortASelect,
		readWritePortBSelect, dataIn, carryInput, regfileWriteEnable, regfileLsbShiftIn,
		regfileMsbShiftIn, accumLsbShiftIn, accumMsbShiftIn};

	// =====================================================================
	// next state
	always_comb begin
		next_cur = cur;
		next_cur.pinSync1 = pinsNow;
		next_cur.pinSync2 = cur.pinSync1;
		p = cur.pinSync2;

		// read ports; the write lands only at the closing edge, so these hold like latches
		aLatch = cur.regFile[p.aSel];
		bLatch = cur.regFile[p.bSel];

		// operand selection
		case (source_t'(p.src))
			SRC_A_Q: begin rOp = aLatch; sOp = cur.q; end
			SRC_A_B: begin rOp = aLatch; sOp = bLatch; end
			SRC_Z_Q: begin rOp = 4'h0; sOp = cur.q; end
			SRC_Z_B: begin rOp = 4'h0; sOp = bLatch; end
			SRC_Z_A: begin rOp = 4'h0; sOp = aLatch; end
			SRC_D_A: begin rOp = p.data; sOp = aLatch; end
			SRC_D_Q: begin rOp = p.data; sOp = cur.q; end
			SRC_D_Z: begin rOp = p.data; sOp = 4'h0; end
			default: begin rOp = 4'h0; sOp = 4'h0; end
		endcase

		// subtraction is complement-and-add so carry-in acts as the +1
		addA = (function_t'(p.fn) == FN_S_MINUS_R) ? ~rOp : rOp;
		addB = (function_t'(p.fn) == FN_R_MINUS_S) ? ~sOp : sOp;
		sum = {1'b0, addA} + {1'b0, addB} + {4'h0, p.cin};
		// carry into the top bit, kept apart for the overflow flag
		lowSum = {1'b0, addA[2:0]} + {1'b0, addB[2:0]} + {3'h0, p.cin};
		// generate and propagate look at the adder inputs after any complement
		g = addA & addB;
		pr = addA | addB;
		arith = 1'b0;

		case (function_t'(p.fn))
			FN_ADD, FN_S_MINUS_R, FN_R_MINUS_S: begin
				f = sum[3:0];
				arith = 1'b1;
			end
			FN_OR: f = rOp | sOp;
			FN_AND: f = rOp & sOp;
			FN_NOT_R_AND_S: f = ~rOp & sOp;
			FN_XOR: f = rOp ^ sOp;
			FN_XNOR: f = ~(rOp ^ sOp);
			default: f = 4'h0;
		endcase

		// carry flags only mean something for arithmetic; logic ops leave them inactive
		next_cur.carryOut = arith & sum[4];
		next_cur.overflow = arith & (lowSum[3] ^ sum[4]);
		next_cur.gen_b = ~(arith & (g[3] | (pr[3] & g[2]) | (pr[3] & pr[2] & g[1]) |
			(pr[3] & pr[2] & pr[1] & g[0])));
		next_cur.prop_b = ~(arith & (&pr));
		next_cur.sign = f[3];
		// open drain: the pin only pulls low; a released line reads as zero found
		next_cur.zeroOut = 1'b0;
		next_cur.zeroOe_b = (f == 4'h0);

		// destination: default releases all shift pins, F on Y, no writes
		next_cur.y = f;
		next_cur.shiftOut = 4'h0;
		next_cur.shiftOe_b = 4'hf;
		rfWrite = 1'b0;
		rfData = f;
		case (destination_t'(p.dst))
			DST_Q_LOAD: next_cur.q = f;
			DST_NONE: ;
			DST_RF_Y_A: begin
				rfWrite = 1'b1;
				next_cur.y = aLatch;
			end
			DST_RF: rfWrite = 1'b1;
			DST_RF_Q_DOWN, DST_RF_DOWN: begin
				rfWrite = 1'b1;
				rfData = {p.ramMsbIn, f[3:1]};
				next_cur.shiftOut[0] = f[0];
				next_cur.shiftOe_b[0] = 1'b0;
				next_cur.shiftOut[2] = cur.q[0];
				next_cur.shiftOe_b[2] = 1'b0;
				if (destination_t'(p.dst) == DST_RF_Q_DOWN) begin
					next_cur.q = {p.qMsbIn, cur.q[3:1]};
				end
			end
			DST_RF_Q_UP, DST_RF_UP: begin
				rfWrite = 1'b1;
				rfData = {f[2:0], p.ramLsbIn};
				next_cur.shiftOut[1] = f[3];
				next_cur.shiftOe_b[1] = 1'b0;
				next_cur.shiftOut[3] = cur.q[3];
				next_cur.shiftOe_b[3] = 1'b0;
				if (destination_t'(p.dst) == DST_RF_Q_UP) begin
					next_cur.q = {cur.q[2:0], p.qLsbIn};
				end
			end
			default: ;
		endcase
		// the low phase ends at the next rising edge, which is where the word lands
		// codes 0 and 1 never store, whatever the enable pin says
		if (rfWrite && p.wen) begin
			next_cur.regFile[p.bSel] = rfData;
		end
		next_cur.yOe_b = ~cur.yEnable;

		// AXI4-Lite write side
		// address and data are taken in either order; the answer waits for both
		if (s_axi_awvalid && cur.awReady) begin
			next_cur.awGot = 1'b1;
			next_cur.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur.wReady) begin
			next_cur.wGot = 1'b1;
			next_cur.wData = s_axi_wdata;
			next_cur.wStrb = s_axi_wstrb;
		end
		if (cur.bValid && s_axi_bready) begin
			next_cur.bValid = 1'b0;
		end
		if (cur.awGot && cur.wGot) begin
			next_cur.awGot = 1'b0;
			next_cur.wGot = 1'b0;
			next_cur.bValid = 1'b1;
			if (cur.awAddr == CONTROL_OFFSET) begin
				next_cur.bResp = RESP_OKAY;
				if (cur.wStrb[0]) begin
					next_cur.yEnable = cur.wData[CTRL_Y_ENABLE_BIT];
				end
			end else if (cur.awAddr == STATUS_OFFSET) begin
				next_cur.bResp = RESP_OKAY;
			end else begin
				next_cur.bResp = RESP_SLVERR;
			end
		end
		next_cur.awReady = ~next_cur.awGot & ~next_cur.bValid & ~(cur.awGot & cur.wGot);
		next_cur.wReady = ~next_cur.wGot & ~next_cur.bValid & ~(cur.awGot & cur.wGot);

		// AXI4-Lite read side
		// one read waits at a time; arready stays low until rready takes the answer
		statusWord = 32'h0;
		statusWord[STAT_Q_LSB +: 4] = cur.q;
		statusWord[STAT_CARRY_BIT] = cur.carryOut;
		statusWord[STAT_OVERFLOW_BIT] = cur.overflow;
		statusWord[STAT_SIGN_BIT] = cur.sign;
		statusWord[STAT_ZERO_BIT] = cur.zeroOe_b;
		statusWord[STAT_GENERATE_B_BIT] = cur.gen_b;
		statusWord[STAT_PROPAGATE_B_BIT] = cur.prop_b;
		if (cur.rValid && s_axi_rready) begin
			next_cur.rValid = 1'b0;
		end
		if (s_axi_arvalid && cur.arReady) begin
			next_cur.rValid = 1'b1;
			if (s_axi_araddr == CONTROL_OFFSET) begin
				next_cur.rData = {31'h0, cur.yEnable};
				next_cur.rResp = RESP_OKAY;
			end else if (s_axi_araddr == STATUS_OFFSET) begin
				next_cur.rData = statusWord;
				next_cur.rResp = RESP_OKAY;
			end else begin
				next_cur.rData = 32'h0;
				next_cur.rResp = RESP_SLVERR;
			end
		end
		next_cur.arReady = ~next_cur.rValid;
	end

	// =====================================================================
	// state register; the register file is cleared too, which the bare slice never did
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			cur <= '0;
			// enables come up released so no line fights a neighbour
			cur.yOe_b <= 1'b1;
			cur.gen_b <= 1'b1;
			cur.prop_b <= 1'b1;
			cur.zeroOe_b <= 1'b1;
			cur.shiftOe_b <= 4'hf;
			cur.yEnable <= CONTROL_RESET[CTRL_Y_ENABLE_BIT];
			cur.awReady <= 1'b1;
			cur.wReady <= 1'b1;
			cur.arReady <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// =====================================================================
	// outputs
	assign yOut = cur.y;
	assign yOe_b = cur.yOe_b;
	assign signBitOut = cur.sign;
	assign carryOutput = cur.carryOut;
	assign overflowFlag = cur.overflow;
	assign generate_b = cur.gen_b;
	assign propagate_b = cur.prop_b;
	assign zeroOut = cur.zeroOut;
	assign zeroOe_b = cur.zeroOe_b;
	// shiftOut order: file lsb, file msb, q lsb, q msb
	assign regfileLsbShiftOut = cur.shiftOut[0];
	assign regfileLsbShiftOe_b = cur.shiftOe_b[0];
	assign regfileMsbShiftOut = cur.shiftOut[1];
	assign regfileMsbShiftOe_b = cur.shiftOe_b[1];
	assign accumLsbShiftOut = cur.shiftOut[2];
	assign accumLsbShiftOe_b = cur.shiftOe_b[2];
	assign accumMsbShiftOut = cur.shiftOut[3];
	assign accumMsbShiftOe_b = cur.shiftOe_b[3];
	assign s_axi_awready = cur.awReady;
	assign s_axi_wready = cur.wReady;
	assign s_axi_bresp = cur.bResp;
	assign s_axi_bvalid = cur.bValid;
	assign s_axi_arready = cur.arReady;
	assign s_axi_rdata = cur.rData;
	assign s_axi_rresp = cur.rResp;
	assign s_axi_rvalid = cur.rValid;

endmodule

/* File: rtl/alu_slice_pkg.sv */
// constants, codes and types shared by the four-bit datapath slice
package alu_slice_pkg;

	// =====================================================================
	// register map of the bus slave (byte addresses)
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

	// CONTROL fields
	localparam int CTRL_Y_ENABLE_BIT = 0;

	// STATUS fields (read only)
	localparam int STAT_Q_LSB = 0;
	localparam int STAT_CARRY_BIT = 4;
	localparam int STAT_OVERFLOW_BIT = 5;
	localparam int STAT_SIGN_BIT = 6;
	localparam int STAT_ZERO_BIT = 7;
	localparam int STAT_GENERATE_B_BIT = 8;
	localparam int STAT_PROPAGATE_B_BIT = 9;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =====================================================================
	// microinstruction fields, codes in octal order 0..7
	typedef enum logic [2:0] {
		SRC_A_Q, SRC_A_B, SRC_Z_Q, SRC_Z_B, SRC_Z_A, SRC_D_A, SRC_D_Q, SRC_D_Z
	} source_t;

	typedef enum logic [2:0] {
		FN_ADD, FN_S_MINUS_R, FN_R_MINUS_S, FN_OR, FN_AND, FN_NOT_R_AND_S, FN_XOR, FN_XNOR
	} function_t;

	typedef enum logic [2:0] {
		DST_Q_LOAD, DST_NONE, DST_RF_Y_A, DST_RF, DST_RF_Q_DOWN, DST_RF_DOWN, DST_RF_Q_UP,
		DST_RF_UP
	} destination_t;

	// =====================================================================
	// sampled pin group
	typedef struct packed {
		logic [2:0] src;
		logic [2:0] fn;
		logic [2:0] dst;
		logic [3:0] aSel;
		logic [3:0] bSel;
		logic [3:0] data;
		logic cin;
		logic wen;
		logic ramLsbIn;
		logic ramMsbIn;
		logic qLsbIn;
		logic qMsbIn;
	} pins_t;

endpackage

/* File: testbench/alu_slice_chk.sv */
// port checker of the datapath slice and its bind
`timescale 1ns/1ps
module alu_slice_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// microinstruction
	input wire logic [2:0] operandSourceSelect,
	input wire logic [2:0] aluFunctionSelect,
	input wire logic [2:0] destinationSelect,
	input wire logic [3:0] dataIn,
	input wire logic carryInput,
	// results
	input wire logic [3:0] yOut,
	input wire logic signBitOut,
	input wire logic carryOutput,
	input wire logic overflowFlag,
	input wire logic generate_b,
	input wire logic propagate_b,
	input wire logic zeroOut,
	input wire logic zeroOe_b,
	// shift lines
	input wire logic regfileLsbShiftOut,
	input wire logic regfileLsbShiftOe_b,
	input wire logic regfileMsbShiftOut,
	input wire logic regfileMsbShiftOe_b,
	input wire logic accumLsbShiftOe_b,
	input wire logic accumMsbShiftOe_b
);
	// =====================================================================
	// instruction history: results lag the pins by three edges
	logic [2:0] warm;
	logic [13:0] h1, h2, h3;
	wire logic ok = warm == 3'h7;
	wire logic [2:0] s = h3[13:11];
	wire logic [2:0] f = h3[10:8];
	wire logic [2:0] d = h3[7:5];
	wire logic [3:0] dd = h3[4:1];
	wire logic c = h3[0];
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) warm <= 3'h0;
		else if (warm != 3'h7) warm <= warm + 3'h1;
	end
	always_ff @(posedge clk) begin
		h1 <= {operandSourceSelect, aluFunctionSelect, destinationSelect, dataIn, carryInput};
		h2 <= h1;
		h3 <= h2;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// =====================================================================
	// properties
	property p_pass;
		ok && s == 3'h7 && f == 3'h3 && d != 3'h2 |-> yOut == dd;
	endproperty
	a_pass: assert property (p_pass) else $error("pass result not data input");
	property p_add;
		ok && s == 3'h7 && f == 3'h0 && d != 3'h2 |-> {carryOutput, yOut} == {1'b0, dd} + 5'(c);
	endproperty
	a_add: assert property (p_add) else $error("carry-in not added");
	property p_logic;
		ok && f >= 3'h3 |-> !carryOutput && !overflowFlag && generate_b && propagate_b;
	endproperty
	a_logic: assert property (p_logic) else $error("logic op flags wrong");
	property p_sign;
		ok && d != 3'h2 |-> signBitOut == yOut[3];
	endproperty
	a_sign: assert property (p_sign) else $error("sign output not result msb");
	property p_zero;
		ok && d != 3'h2 |-> zeroOe_b == (yOut == 4'h0) && !zeroOut;
	endproperty
	a_zero: assert property (p_zero) else $error("zero detect wrong");
	property p_rfdown;
		ok && d inside {3'h4, 3'h5} |-> !regfileLsbShiftOe_b && regfileMsbShiftOe_b
			&& regfileLsbShiftOut == yOut[0];
	endproperty
	a_rfdown: assert property (p_rfdown) else $error("down shift pins wrong");
	property p_rfup;
		ok && d inside {3'h6, 3'h7} |-> !regfileMsbShiftOe_b && regfileLsbShiftOe_b
			&& regfileMsbShiftOut == yOut[3];
	endproperty
	a_rfup: assert property (p_rfup) else $error("up shift pins wrong");
	property p_qshift;
		ok && d[2] |-> accumLsbShiftOe_b == d[1] && accumMsbShiftOe_b == !d[1];
	endproperty
	a_qshift: assert property (p_qshift) else $error("q shift pins wrong");
	property p_idle;
		ok && !d[2] |-> regfileLsbShiftOe_b && regfileMsbShiftOe_b && accumLsbShiftOe_b
			&& accumMsbShiftOe_b;
	endproperty
	a_idle: assert property (p_idle) else $error("shift line not released");
	property p_gsub;
		ok && s == 3'h7 && f == 3'h2 |-> generate_b == !(|dd) && !propagate_b;
	endproperty
	a_gsub: assert property (p_gsub) else $error("subtract lookahead outputs wrong");
	property p_padd;
		ok && s == 3'h7 && f == 3'h0 |-> generate_b && propagate_b == !(&dd);
	endproperty
	a_padd: assert property (p_padd) else $error("add lookahead outputs wrong");
endmodule

bind alu_slice alu_slice_chk chk (.clk, .rst_b, .operandSourceSelect, .aluFunctionSelect,
	.destinationSelect, .dataIn, .carryInput, .yOut, .signBitOut, .carryOutput, .overflowFlag,
	.generate_b, .propagate_b, .zeroOut, .zeroOe_b, .regfileLsbShiftOut, .regfileLsbShiftOe_b,
	.regfileMsbShiftOut, .regfileMsbShiftOe_b, .accumLsbShiftOe_b, .accumMsbShiftOe_b);

/* File: testbench/alu_slice_tb.sv */
// self-checking bench of the datapath slice
`timescale 1ns/1ps
module alu_slice_tb import alu_slice_pkg::*; ;
	// =====================================================================
	// signals and reference state
	logic clk, rst_b;
	pins_t pin;
	logic [3:0] fill, lineIn, yOut, q;
	logic yOe_b, signBitOut, carryOutput, overflowFlag, generate_b, propagate_b, zeroOut, zeroOe_b;
	logic regfileLsbShiftOut, regfileLsbShiftOe_b, regfileMsbShiftOut, regfileMsbShiftOe_b;
	logic accumLsbShiftOut, accumLsbShiftOe_b, accumMsbShiftOut, accumMsbShiftOe_b;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] rf [16];
	int nMismatch, nChecks, cyc;
	localparam pins_t NOP = '{default: '0, dst: 3'h1};
	alu_slice DUT (.clk, .rst_b, .operandSourceSelect(pin.src), .aluFunctionSelect(pin.fn),
		.destinationSelect(pin.dst), .readPortASelect(pin.aSel), .readWritePortBSelect(pin.bSel),
		.dataIn(pin.data), .carryInput(pin.cin), .regfileWriteEnable(pin.wen),
		.yOut, .yOe_b, .signBitOut, .carryOutput, .overflowFlag, .generate_b, .propagate_b,
		.zeroOut, .zeroOe_b, .regfileLsbShiftIn(lineIn[3]), .regfileLsbShiftOut,
		.regfileLsbShiftOe_b, .regfileMsbShiftIn(lineIn[2]), .regfileMsbShiftOut,
		.regfileMsbShiftOe_b, .accumLsbShiftIn(lineIn[1]), .accumLsbShiftOut, .accumLsbShiftOe_b,
		.accumMsbShiftIn(lineIn[0]), .accumMsbShiftOut, .accumMsbShiftOe_b, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	shift_neighbour nbr (.fill, .sliceOut({regfileLsbShiftOut, regfileMsbShiftOut,
		accumLsbShiftOut, accumMsbShiftOut}), .sliceOe_b({regfileLsbShiftOe_b,
		regfileMsbShiftOe_b, accumLsbShiftOe_b, accumMsbShiftOe_b}), .lineIn);
	// =====================================================================
	// tasks
	task automatic closeOut();
		if (nMismatch == 0 && nChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			nMismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] ops(input logic [2:0] s, input logic [3:0] ra, rb, dv, rq);
		case (s)
			3'h0: return {ra, rq};
			3'h1: return {ra, rb};
			3'h2: return {4'h0, rq};
			3'h3: return {4'h0, rb};
			3'h4: return {4'h0, ra};
			3'h5: return {dv, ra};
			3'h6: return {dv, rq};
			default: return {dv, 4'h0};
		endcase
	endfunction
	// returns {overflow, carry, result}; subtraction is complement plus carry-in
	function automatic logic [5:0] alu(input logic [2:0] f, input logic [3:0] r, s, input logic c);
		logic [3:0] u, v, y;
		logic [4:0] x;
		u = (f == 3'h1) ? ~r : r;
		v = (f == 3'h2) ? ~s : s;
		x = {1'b0, u} + {1'b0, v} + 5'(c);
		y = {1'b0, u[2:0]} + {1'b0, v[2:0]} + 4'(c);
		case (f)
			3'h0, 3'h1, 3'h2: return {y[3] ^ x[4], x};
			3'h3: return {2'b00, r | s};
			3'h4: return {2'b00, r & s};
			3'h5: return {2'b00, ~r & s};
			3'h6: return {2'b00, r ^ s};
			default: return {2'b00, ~(r ^ s)};
		endcase
	endfunction
	// one instruction for one cycle, then idle until its results show
	task automatic ex(input logic [2:0] s, f, t, input logic [3:0] ra, rb, dv,
		input logic ci, we, input logic [3:0] fl);
		logic [7:0] o;
		logic [5:0] r;
		o = ops(s, rf[ra], rf[rb], dv, q);
		r = alu(f, o[7:4], o[3:0], ci);
		@(posedge clk);
		pin <= '{s, f, t, ra, rb, dv, ci, we, 1'b0, 1'b0, 1'b0, 1'b0};
		fill <= fl;
		@(posedge clk);
		pin <= NOP;
		repeat (2) @(posedge clk);
		#1;
		chk("yOut", t == 3'h2 ? rf[ra] : r[3:0], yOut);
		chk("flags", {r[5:3], r[3:0] == 4'h0},
			{overflowFlag, carryOutput, signBitOut, zeroOe_b});
		if (t[2]) chk("qShiftOut", t[1] ? q[3] : q[0],
			t[1] ? accumMsbShiftOut : accumLsbShiftOut);
		if (we && t > 3'h1) rf[rb] = !t[2] ? r[3:0] : t[1] ? {r[2:0], fl[3]} : {fl[2], r[3:1]};
		if (t == 3'h0) q = r[3:0];
		if (t == 3'h4) q = {fl[0], q[3:1]};
		if (t == 3'h6) q = {q[2:0], fl[1]};
	endtask
	task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] rsp);
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] ad, output logic [31:0] dat, output logic [1:0] rsp);
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		dat = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	// =====================================================================
	// clock, timeout and test sequence
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			nMismatch++;
			closeOut();
		end
	end
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		pin = NOP;
		fill = 4'h0;
		q = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		foreach (rf[i]) rf[i] = 4'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		axr(CONTROL_OFFSET, rd, rs);
		chk("control", CONTROL_RESET, rd);
		for (int i = 0; i < 16; i++)
			ex(3'h7, 3'h3, 3'h3, 4'h0, 4'(i), 4'(i * 7), 1'b0, 1'b1, 4'h0);
		ex(3'h7, 3'h3, 3'h3, 4'h0, 4'h1, 4'h5, 1'b0, 1'b0, 4'h0);
		for (int i = 0; i < 16; i++) begin
			ex(3'h1, 3'h6, 3'h1, 4'(i), 4'(i), 4'h0, 1'b0, 1'b1, 4'h0);
			ex(3'h4, 3'h3, 3'h1, 4'(i), 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
			ex(3'h3, 3'h3, 3'h1, 4'h0, 4'(i), 4'h0, 1'b0, 1'b0, 4'h0);
		end
		ex(3'h7, 3'h3, 3'h0, 4'h0, 4'h0, 4'h9, 1'b0, 1'b0, 4'h0);
		ex(3'h7, 3'h0, 3'h1, 4'h0, 4'h0, 4'hf, 1'b1, 1'b0, 4'h0);
		for (int s = 0; s < 8; s++)
			for (int f = 0; f < 32; f++)
				ex(3'(s), f[2:0], 3'h1, 4'h3, 4'h6, f[4] ? 4'hc : 4'h7, f[3], 1'b0, 4'h0);
		for (int t = 0; t < 8; t++) begin
			ex(3'h1, 3'h0, 3'(t), 4'h2, 4'h5, 4'h0, 1'b1, 1'b1, 4'(t * 5));
			ex(3'h3, 3'h3, 3'h1, 4'h0, 4'h5, 4'h0, 1'b0, 1'b0, 4'h0);
			ex(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
		end
		axw(CONTROL_OFFSET, 32'h0, rs);
		chk("writeResp", RESP_OKAY, rs);
		ex(3'h7, 3'h3, 3'h1, 4'h0, 4'h0, 4'h8, 1'b0, 1'b0, 4'h0);
		chk("yOe_b", 1'b1, yOe_b);
		axw(CONTROL_OFFSET, 32'h1, rs);
		axr(STATUS_OFFSET, rd, rs);
		chk("statusQ", q, rd[3:0]);
		chk("yOe_b", 1'b0, yOe_b);
		axr(8'h08, rd, rs);
		chk("unmappedData", 32'h0, rd);
		chk("unmappedRead", RESP_SLVERR, rs);
		axw(8'h0c, 32'h1, rs);
		chk("unmappedWrite", RESP_SLVERR, rs);
		closeOut();
	end
endmodule

/* File: testbench/shift_neighbour.sv */
// neighbouring slices on the four shift lines
`timescale 1ns/1ps
module shift_neighbour (
	// fill bits offered by the neighbours, {rfLsb, rfMsb, qLsb, qMsb}
	input wire logic [3:0] fill,
	// slice side of the lines
	input wire logic [3:0] sliceOut,
	input wire logic [3:0] sliceOe_b,
	// resolved line levels
	output logic [3:0] lineIn
);
	// =====================================================================
	// a neighbour drives only while the slice lets go, so no line floats
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lineIn[i] = sliceOe_b[i] ? fill[i] : sliceOut[i];
		end
	end
endmodule
